// [inc/osc_pkg.sv]
package osc_pkg;
  localparam logic [3:0]  REG_TRIM        = 4'h0;
  localparam logic [3:0]  REG_CTRL        = 4'h4;
  localparam logic [3:0]  REG_STAT        = 4'h8;
  localparam logic [7:0]  TRIM_RESET      = 8'h00;
  localparam int          TRIM_LFSEL_BIT  = 7;
  localparam int          TRIM_SOFT_BIT   = 6;
  localparam int          CTRL_SCS_LSB    = 0;
  localparam int          CTRL_IRCF_LSB   = 4;
  localparam logic [1:0]  CTRL_SCS_RESET  = 2'h0;
  localparam logic [2:0]  CTRL_IRCF_RESET = 3'h3;
  localparam logic [2:0]  IRCF_8MHZ       = 3'h6;
  localparam logic [2:0]  IRCF_LOWEST     = 3'h0;
  localparam int          STAT_DONE       = 0;
  localparam int          STAT_BUSY       = 1;
  localparam int          STAT_SRC_LSB    = 2;
  localparam int          STAT_MULT       = 4;
  localparam int          STAT_HOLD       = 5;
  localparam logic [3:0]  PCFG_LP         = 4'h0;
  localparam logic [3:0]  PCFG_XT         = 4'h1;
  localparam logic [3:0]  PCFG_HS         = 4'h2;
  localparam logic [3:0]  PCFG_RC         = 4'h3;
  localparam logic [3:0]  PCFG_INT_A      = 4'h8;
  localparam logic [3:0]  PCFG_INT_B      = 4'h9;
  localparam logic [10:0] OST_CRYSTAL     = 11'h400;
  localparam logic [10:0] OST_EXT         = 11'h008;
  localparam logic [10:0] OST_WARMUP      = 11'h010;
  localparam logic [1:0]  SRC_PRI         = 2'h0;
  localparam logic [1:0]  SRC_SEC         = 2'h1;
  localparam logic [1:0]  SRC_INT         = 2'h2;
  localparam int          SYNC_W          = 15;

  typedef enum logic [1:0] {CLS_CRYSTAL, CLS_EXT, CLS_INT} osc_cls_t;
  typedef enum logic [2:0] {SW_IDLE, SW_OLD_EDGES, SW_WAIT_FALL, SW_NEW_EDGES, SW_NEW_FALL} osc_sw_state_t;

  function automatic osc_cls_t cls_of(input logic [3:0] cfg);
    if (cfg == PCFG_INT_A || cfg == PCFG_INT_B) begin
      return CLS_INT;
    end
    if (cfg == PCFG_LP || cfg == PCFG_XT || cfg == PCFG_HS) begin
      return CLS_CRYSTAL;
    end
    return CLS_EXT;
  endfunction : cls_of

  function automatic logic [10:0] ost_target(input osc_cls_t c);
    case (c)
      CLS_CRYSTAL: return OST_CRYSTAL;
      CLS_INT:     return OST_WARMUP;
      default:     return OST_EXT;
    endcase
  endfunction : ost_target
endpackage : osc_pkg

// [inc/osc_switch_if.sv]
`timescale 1ns/1ns
interface osc_switch_if;
  logic [2:0] src_level;
  logic [2:0] src_ready;
  logic [1:0] target;
  logic [1:0] active;
  logic       busy;
  logic       clk_out;
  modport ctrl (output src_level, output src_ready, output target, input active, input busy, input clk_out);
  modport sw (input src_level, input src_ready, input target, output active, output busy, output clk_out);
endinterface : osc_switch_if

// [logic/osc_clock_control.sv]
`timescale 1ns/1ns
module osc_clock_control
  import osc_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        OSCILLATOR_INPUT_PIN,
  input  wire logic        SECONDARY_OSC_CLK,
  input  wire logic        SECONDARY_OSC_READY,
  input  wire logic        FAST_INTERNAL_OSC,
  input  wire logic        SLOW_INTERNAL_OSC,
  input  wire logic        MULTIPLIER_CLK,
  input  wire logic        BROWN_OUT_RESET,
  input  wire logic        WAKE_FROM_SLEEP,
  input  wire logic        OSC_ENABLE,
  input  wire logic        POWER_UP_TIMER_DONE,
  input  wire logic        CONFIG_MULTIPLIER_ENABLE,
  input  wire logic [3:0]  PRIMARY_CLOCK_CONFIG,
  output logic      [5:0]  FREQ_TRIM_FIELD,
  output logic             LOW_FREQ_SOURCE_SELECT,
  output logic             SOFT_MULTIPLIER_ENABLE,
  output logic             MULTIPLIER_ENABLE,
  output logic             MULTIPLIER_INPUT_INTERNAL,
  output logic             CPU_HOLD,
  output logic             SYS_CLK_OUT
);
  osc_switch_if sw ();

  // Every pin except the bus inputs, CLK_SYS and RSTN passes two flip-flops before any logic reads it.
  logic [SYNC_W-1:0] sync1, sync2;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {OSCILLATOR_INPUT_PIN, SECONDARY_OSC_CLK, SECONDARY_OSC_READY, FAST_INTERNAL_OSC,
                SLOW_INTERNAL_OSC, MULTIPLIER_CLK, BROWN_OUT_RESET, WAKE_FROM_SLEEP, OSC_ENABLE,
                POWER_UP_TIMER_DONE, CONFIG_MULTIPLIER_ENABLE, PRIMARY_CLOCK_CONFIG};
      sync2 <= sync1;
    end
  end

  logic       pri_pin, sec_clk, sec_rdy, fast_osc, slow_osc, mult_clk, cfg_mult;
  logic [3:0] events, cfg_prim;
  assign {pri_pin, sec_clk, sec_rdy, fast_osc, slow_osc, mult_clk, events, cfg_mult, cfg_prim} = sync2;

  // Register file.
  logic [7:0]  trim, next_trim;
  logic [1:0]  scs, next_scs;
  logic [2:0]  ircf, next_ircf;
  logic        wait_req, next_wait_req;
  logic [31:0] rdata, next_rdata;
  logic [7:0]  status;
  logic        su_done, cpu_hold, mult_en;

  assign status = {2'h0, cpu_hold, mult_en, sw.active, sw.busy, su_done};

  function automatic logic [31:0] read_mux(input logic [3:0] a, input logic [7:0] t, input logic [7:0] c,
                                           input logic [7:0] s);
    case (a)
      REG_TRIM: return {24'h000000, t};
      REG_CTRL: return {24'h000000, c};
      REG_STAT: return {24'h000000, s};
      default:  return 32'h00000000;
    endcase
  endfunction : read_mux

  always_comb begin
    next_trim     = trim;
    next_scs      = scs;
    next_ircf     = ircf;
    next_wait_req = 1'b1;
    next_rdata    = rdata;
    if ((AVS_READ || AVS_WRITE) && wait_req) begin
      next_wait_req = 1'b0;
      next_rdata    = read_mux(AVS_ADDRESS, trim, {1'b0, ircf, 2'h0, scs}, status);
    end
    if (AVS_WRITE && !wait_req && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == REG_TRIM) begin
        next_trim = AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == REG_CTRL) begin
        next_scs  = AVS_WRITEDATA[CTRL_SCS_LSB +: 2];
        next_ircf = AVS_WRITEDATA[CTRL_IRCF_LSB +: 3];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      trim     <= TRIM_RESET;
      scs      <= CTRL_SCS_RESET;
      ircf     <= CTRL_IRCF_RESET;
      wait_req <= 1'b1;
      rdata    <= 32'h00000000;
    end else begin
      trim     <= next_trim;
      scs      <= next_scs;
      ircf     <= next_ircf;
      wait_req <= next_wait_req;
      rdata    <= next_rdata;
    end
  end

  assign AVS_READDATA           = rdata;
  assign AVS_WAITREQUEST        = wait_req;
  assign FREQ_TRIM_FIELD        = trim[5:0];
  assign LOW_FREQ_SOURCE_SELECT = trim[TRIM_LFSEL_BIT];
  assign SOFT_MULTIPLIER_ENABLE = trim[TRIM_SOFT_BIT];

  // Postscaler on the fast internal oscillator.
  logic [8:0] div, next_div;
  logic [3:0] ev_prev;
  logic       fast_prev, ref_prev;
  logic       fast_rise, ref_rise, restart, int_clk;
  osc_cls_t   cls;

  assign cls       = cls_of(cfg_prim);
  assign fast_rise = fast_osc & ~fast_prev;

  always_comb begin
    next_div = div;
    if (fast_rise) begin
      next_div = div + 9'h001;
    end
  end

  always_comb begin
    case (ircf)
      3'h7:    int_clk = fast_osc;
      3'h6:    int_clk = div[0];
      3'h5:    int_clk = div[1];
      3'h4:    int_clk = div[2];
      3'h3:    int_clk = div[3];
      3'h2:    int_clk = div[4];
      3'h1:    int_clk = div[5];
      default: int_clk = trim[TRIM_LFSEL_BIT] ? div[8] : slow_osc;
    endcase
  end

  // Start-up counter on the primary reference.
  logic [10:0] su_cnt, next_su_cnt;
  logic        next_su_done, ref_lv;

  assign ref_lv   = (cls == CLS_INT) ? fast_osc : pri_pin;
  assign ref_rise = ref_lv & ~ref_prev;
  assign restart  = |(events & ~ev_prev);

  always_comb begin
    next_su_cnt  = su_cnt;
    next_su_done = su_done;
    if (restart) begin
      next_su_cnt  = 11'h000;
      next_su_done = 1'b0;
    end else if (!su_done && ref_rise) begin
      next_su_cnt = su_cnt + 11'h001;
      if (next_su_cnt >= ost_target(cls)) begin
        next_su_done = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      div       <= 9'h000;
      su_cnt    <= 11'h000;
      su_done   <= 1'b0;
      fast_prev <= 1'b0;
      ref_prev  <= 1'b0;
      ev_prev   <= 4'h0;
    end else begin
      div       <= next_div;
      su_cnt    <= next_su_cnt;
      su_done   <= next_su_done;
      fast_prev <= fast_osc;
      ref_prev  <= ref_lv;
      ev_prev   <= events;
    end
  end

  // Multiplier control and source levels.
  logic pll_on, pll_int, prim_int, next_cpu_hold, next_mult_int, mult_int, pri_level;

  assign pll_on   = cfg_mult | trim[TRIM_SOFT_BIT];
  assign prim_int = (cls == CLS_INT);
  // internal use only at 8 MHz
  assign pll_int  = pll_on && scs == SRC_PRI && prim_int && ircf == IRCF_8MHZ;
  assign pri_level = prim_int ? (pll_int ? mult_clk : int_clk) : (pll_on ? mult_clk : pri_pin);

  always_comb begin
    next_mult_int = prim_int && scs == SRC_PRI;
    next_cpu_hold = !su_done && cls == CLS_CRYSTAL && scs == SRC_PRI;
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mult_en  <= 1'b0;
      mult_int <= 1'b0;
      cpu_hold <= 1'b0;
    end else begin
      mult_en  <= pll_on;
      mult_int <= next_mult_int;
      cpu_hold <= next_cpu_hold;
    end
  end

  assign MULTIPLIER_ENABLE         = mult_en;
  assign MULTIPLIER_INPUT_INTERNAL = mult_int;
  assign CPU_HOLD                  = cpu_hold;

  assign sw.target    = scs[1] ? SRC_INT : (scs[0] ? SRC_SEC : SRC_PRI);
  assign sw.src_level = {int_clk, sec_clk, pri_level};
  assign sw.src_ready = {1'b1, sec_rdy, su_done};

  osc_glitch_switch u_switch (
    .clk  (CLK_SYS),
    .rstn (RSTN),
    .sw   (sw.sw)
  );

  assign SYS_CLK_OUT = sw.clk_out;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  a_trim_reset_zero: assert property ($rose(RSTN) |-> trim == TRIM_RESET)
    else $error("Trim not zero after reset");
  a_trim_write_out: assert property (AVS_WRITE && !wait_req && AVS_BYTEENABLE[0] && AVS_ADDRESS == REG_TRIM
      |=> FREQ_TRIM_FIELD == $past(AVS_WRITEDATA[5:0]))
    else $error("Trim output did not follow write");
  a_slow_unaffected: assert property (ircf == IRCF_LOWEST && !trim[TRIM_LFSEL_BIT] |-> int_clk == slow_osc)
    else $error("Slow source not passed straight through");
  a_lowfreq_div: assert property (ircf == IRCF_LOWEST && trim[TRIM_LFSEL_BIT] |-> int_clk == div[8])
    else $error("Lowest option not fast divided by 512");
  a_crystal_count: assert property ($rose(su_done) && cls == CLS_CRYSTAL |-> su_cnt == OST_CRYSTAL)
    else $error("Crystal start-up ended before 1024 oscillations");
  a_cpu_held: assert property (!su_done && cls == CLS_CRYSTAL && scs == SRC_PRI |=> CPU_HOLD)
    else $error("CPU not held during start-up");
  a_restart_count: assert property (restart |=> su_cnt == 11'h000 && !su_done)
    else $error("Start-up period not restarted");
  a_mult_enable: assert property (##1 MULTIPLIER_ENABLE == $past(cfg_mult | trim[TRIM_SOFT_BIT]))
    else $error("Multiplier enable wrong");
  a_mult_not_1x: assert property (scs[1] |-> !pll_int)
    else $error("Multiplier applied with internal block select");
  a_wait_answer: assert property (AVS_READ && wait_req |=> !wait_req ##1 wait_req)
    else $error("Bus answer not one cycle wide");
  c_crystal_done: cover property ($rose(su_done) && cls == CLS_CRYSTAL);
  c_pll_internal: cover property (pll_int && cfg_mult);
  c_trim_write: cover property (AVS_WRITE && !wait_req && AVS_ADDRESS == REG_TRIM);
endmodule : osc_clock_control

// [logic/osc_glitch_switch.sv]
`timescale 1ns/1ns
module osc_glitch_switch
  import osc_pkg::*;
(
  input wire logic   clk,
  input wire logic   rstn,
  osc_switch_if.sw   sw
);
  osc_sw_state_t state, next_state;
  logic [1:0]    active, next_active;
  logic [1:0]    tgt, next_tgt;
  logic [1:0]    cnt, next_cnt;
  logic          clk_out, next_clk_out;
  logic [2:0]    prev;
  logic          old_lv, new_lv, old_rise, old_fall, new_rise, new_fall;

  assign old_lv   = sw.src_level[active];
  assign new_lv   = sw.src_level[tgt];
  assign old_rise = old_lv & ~prev[active];
  assign old_fall = ~old_lv & prev[active];
  assign new_rise = new_lv & ~prev[tgt];
  assign new_fall = ~new_lv & prev[tgt];
  assign sw.active  = active;
  assign sw.busy    = (state != SW_IDLE) || (sw.target != active);
  assign sw.clk_out = clk_out;

  always_comb begin
    next_state   = state;
    next_active  = active;
    next_tgt     = tgt;
    next_cnt     = cnt;
    next_clk_out = old_lv;
    case (state)
      SW_IDLE: begin
        if (sw.target != active && sw.src_ready[sw.target]) begin
          next_tgt   = sw.target;
          next_cnt   = 2'h0;
          next_state = SW_OLD_EDGES;
        end
      end
      SW_OLD_EDGES: begin
        if (old_rise) begin
          next_cnt = cnt + 2'h1;
          if (cnt == 2'h1) begin
            next_state = SW_WAIT_FALL;
          end
        end
      end
      SW_WAIT_FALL: begin
        if (old_fall) begin
          next_clk_out = 1'b0;
          next_cnt     = 2'h0;
          next_state   = SW_NEW_EDGES;
        end
      end
      SW_NEW_EDGES: begin
        next_clk_out = 1'b0;
        if (new_rise) begin
          next_cnt = cnt + 2'h1;
          if (cnt == 2'h1) begin
            next_state = SW_NEW_FALL;
          end
        end
      end
      SW_NEW_FALL: begin
        next_clk_out = 1'b0;
        if (new_fall) begin
          next_active = tgt;
          next_state  = SW_IDLE;
        end
      end
      default: begin
        next_state = SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= SW_IDLE;
      active  <= SRC_PRI;
      tgt     <= SRC_PRI;
      cnt     <= 2'h0;
      clk_out <= 1'b0;
      prev    <= 3'h0;
    end else begin
      state   <= next_state;
      active  <= next_active;
      tgt     <= next_tgt;
      cnt     <= next_cnt;
      clk_out <= next_clk_out;
      prev    <= sw.src_level;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_keep_old_src: assert property (state == SW_IDLE && !sw.src_ready[sw.target] |=> $stable(active))
    else $error("Source changed before new source was ready");
  a_two_old_edges: assert property (state == SW_OLD_EDGES && old_rise && cnt == 2'h1 |=> state == SW_WAIT_FALL)
    else $error("Old edge count did not end after two rising edges");
  a_hold_low_start: assert property (state == SW_WAIT_FALL && old_fall |=> !clk_out [*2])
    else $error("System clock not held low after old falling edge");
  a_release_new: assert property (state == SW_NEW_FALL && new_fall |=> state == SW_IDLE && active == $past(tgt))
    else $error("New clock not switched in on its falling edge");
  c_switch_done: cover property (state == SW_NEW_FALL && new_fall);
endmodule : osc_glitch_switch

// [tb/tb_osc_tune_switch_pll_control.sv]
`timescale 1ns/1ns
module tb_osc_tune_switch_pll_control;
  import osc_pkg::*;
  typedef struct {logic [3:0] addr; logic [7:0] wd; logic [3:0] be; logic [7:0] rd;} osc_row_t;

  logic        CLK_SYS, RSTN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE, PRIMARY_CLOCK_CONFIG;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic        OSCILLATOR_INPUT_PIN, SECONDARY_OSC_CLK, SECONDARY_OSC_READY, FAST_INTERNAL_OSC;
  logic        SLOW_INTERNAL_OSC, MULTIPLIER_CLK, BROWN_OUT_RESET, WAKE_FROM_SLEEP, OSC_ENABLE;
  logic        POWER_UP_TIMER_DONE, CONFIG_MULTIPLIER_ENABLE;
  logic [5:0]  FREQ_TRIM_FIELD;
  logic        LOW_FREQ_SOURCE_SELECT, SOFT_MULTIPLIER_ENABLE, MULTIPLIER_ENABLE;
  logic        MULTIPLIER_INPUT_INTERNAL, CPU_HOLD, SYS_CLK_OUT;
  logic [7:0]  cyc;
  logic        run;
  int          edges, cycles, n_fail, checked;
  logic [31:0] rd;
  logic [7:0]  et;

  osc_row_t rows [6] = '{
    '{REG_TRIM, 8'h1F, 4'hF, 8'h1F}, '{REG_TRIM, 8'h20, 4'h1, 8'h20}, '{REG_TRIM, 8'hBF, 4'h1, 8'hBF},
    '{REG_TRIM, 8'h55, 4'h0, 8'hBF}, '{4'hC, 8'h77, 4'h1, 8'h00}, '{REG_CTRL, 8'h60, 4'h1, 8'h60}};
  logic [3:0]  cfgs [4] = '{4'h4, PCFG_RC, PCFG_INT_A, PCFG_XT};
  int          cnts [4] = '{8, 8, 16, 1024};

  osc_clock_control osc_clock_control_i (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .OSCILLATOR_INPUT_PIN(OSCILLATOR_INPUT_PIN), .SECONDARY_OSC_CLK(SECONDARY_OSC_CLK),
    .SECONDARY_OSC_READY(SECONDARY_OSC_READY), .FAST_INTERNAL_OSC(FAST_INTERNAL_OSC),
    .SLOW_INTERNAL_OSC(SLOW_INTERNAL_OSC), .MULTIPLIER_CLK(MULTIPLIER_CLK),
    .BROWN_OUT_RESET(BROWN_OUT_RESET), .WAKE_FROM_SLEEP(WAKE_FROM_SLEEP), .OSC_ENABLE(OSC_ENABLE),
    .POWER_UP_TIMER_DONE(POWER_UP_TIMER_DONE), .CONFIG_MULTIPLIER_ENABLE(CONFIG_MULTIPLIER_ENABLE),
    .PRIMARY_CLOCK_CONFIG(PRIMARY_CLOCK_CONFIG), .FREQ_TRIM_FIELD(FREQ_TRIM_FIELD),
    .LOW_FREQ_SOURCE_SELECT(LOW_FREQ_SOURCE_SELECT), .SOFT_MULTIPLIER_ENABLE(SOFT_MULTIPLIER_ENABLE),
    .MULTIPLIER_ENABLE(MULTIPLIER_ENABLE), .MULTIPLIER_INPUT_INTERNAL(MULTIPLIER_INPUT_INTERNAL),
    .CPU_HOLD(CPU_HOLD), .SYS_CLK_OUT(SYS_CLK_OUT)
  );

  always #10 CLK_SYS = ~CLK_SYS;

  // Slow stand-in clocks; the pin and fast oscillator only run when enabled.
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 8'h01;
    OSCILLATOR_INPUT_PIN <= run & cyc[2];
    FAST_INTERNAL_OSC <= run & cyc[2];
    MULTIPLIER_CLK <= cyc[1];
    SECONDARY_OSC_CLK <= cyc[3];
    SLOW_INTERNAL_OSC <= cyc[5];
    if (run && cyc[2] && !OSCILLATOR_INPUT_PIN) begin
      edges <= edges + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= 1'b1;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
    AVS_WRITE <= 1'b0;
    @(posedge CLK_SYS);
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
    d = AVS_READDATA;
    AVS_READ <= 1'b0;
    @(posedge CLK_SYS);
  endtask : bus_read

  task automatic wait_edges(input int n);
    int b;
    b = edges;
    while (edges - b < n) @(posedge CLK_SYS);
  endtask : wait_edges

  task automatic wait_src(input logic [1:0] s);
    logic [31:0] r;
    int          k;
    k = 0;
    do begin
      bus_read(REG_STAT, r);
      k++;
    end while (r[STAT_SRC_LSB +: 2] !== s && k < 200);
    check("active_src", {30'h0, s}, {30'h0, r[STAT_SRC_LSB +: 2]});
    check("switch_busy", 32'h0, {31'h0, r[STAT_BUSY]});
  endtask : wait_src

  // Counts rising edges of the system clock over n cycles; a periodic source gives an exact count.
  task automatic check_clk(input int n, input int exp);
    int   k;
    logic last;
    k = 0;
    @(posedge CLK_SYS);
    last = SYS_CLK_OUT;
    repeat (n) begin
      @(posedge CLK_SYS);
      if (SYS_CLK_OUT && !last) k++;
      last = SYS_CLK_OUT;
    end
    check("sys_clk_rises", 32'(exp), 32'(k));
  endtask : check_clk

  initial begin
    CLK_SYS = 0; RSTN = 0; AVS_READ = 0; AVS_WRITE = 0; AVS_ADDRESS = 0; AVS_BYTEENABLE = 0;
    AVS_WRITEDATA = 0; SECONDARY_OSC_READY = 0; BROWN_OUT_RESET = 0; WAKE_FROM_SLEEP = 0;
    OSC_ENABLE = 0; POWER_UP_TIMER_DONE = 0; CONFIG_MULTIPLIER_ENABLE = 0;
    PRIMARY_CLOCK_CONFIG = PCFG_XT; cyc = 0; run = 0; edges = 0; cycles = 0; n_fail = 0; checked = 0;
    OSCILLATOR_INPUT_PIN = 0; FAST_INTERNAL_OSC = 0; SLOW_INTERNAL_OSC = 0;
    SECONDARY_OSC_CLK = 0; MULTIPLIER_CLK = 0; et = TRIM_RESET;
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    // Crystal primary without start-up done holds the CPU.
    check("cpu_hold", 32'h1, {31'h0, CPU_HOLD});
    bus_read(REG_TRIM, rd);
    check("trim_reset", {24'h0, TRIM_RESET}, rd);
    bus_read(REG_CTRL, rd);
    check("ctrl_reset", {24'h0, 1'b0, CTRL_IRCF_RESET, 2'b00, CTRL_SCS_RESET}, rd);
    // Register rows and their registered outputs.
    foreach (rows[i]) begin
      bus_write(rows[i].addr, rows[i].wd, rows[i].be);
      bus_read(rows[i].addr, rd);
      check("readback", {24'h0, rows[i].rd}, rd);
      if (rows[i].addr == REG_TRIM && rows[i].be[0]) et = rows[i].wd;
      check("trim_field", {26'h0, et[5:0]}, {26'h0, FREQ_TRIM_FIELD});
      check("low_freq_sel", {31'h0, et[TRIM_LFSEL_BIT]}, {31'h0, LOW_FREQ_SOURCE_SELECT});
      check("soft_mult", {31'h0, et[TRIM_SOFT_BIT]}, {31'h0, SOFT_MULTIPLIER_ENABLE});
      check("mult_en", {31'h0, et[TRIM_SOFT_BIT]}, {31'h0, MULTIPLIER_ENABLE});
    end
    // Configuration bit overrides a cleared software enable.
    CONFIG_MULTIPLIER_ENABLE <= 1'b1;
    bus_write(REG_TRIM, 8'h00, 4'h1);
    repeat (5) @(posedge CLK_SYS);
    check("mult_cfg", 32'h1, {31'h0, MULTIPLIER_ENABLE});
    bus_read(REG_STAT, rd);
    check("stat_mult", 32'h1, {31'h0, rd[STAT_MULT]});
    CONFIG_MULTIPLIER_ENABLE <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    check("mult_off", 32'h0, {31'h0, MULTIPLIER_ENABLE});
    // Start-up count per mode, each restarted by another event.
    for (int i = 0; i < 4; i++) begin
      run <= 1'b0;
      PRIMARY_CLOCK_CONFIG <= cfgs[i];
      repeat (4) @(posedge CLK_SYS);
      case (i)
        0: BROWN_OUT_RESET <= 1'b1;
        1: WAKE_FROM_SLEEP <= 1'b1;
        2: OSC_ENABLE <= 1'b1;
        default: POWER_UP_TIMER_DONE <= 1'b1;
      endcase
      repeat (4) @(posedge CLK_SYS);
      {BROWN_OUT_RESET, WAKE_FROM_SLEEP, OSC_ENABLE, POWER_UP_TIMER_DONE} <= 4'h0;
      repeat (6) @(posedge CLK_SYS);
      run <= 1'b1;
      wait_edges(cnts[i] - 1);
      repeat (3) @(posedge CLK_SYS);
      bus_read(REG_STAT, rd);
      check("startup_early", 32'h0, {31'h0, rd[STAT_DONE]});
      check("hold_early", {31'h0, i == 3}, {31'h0, CPU_HOLD});
      wait_edges(1);
      repeat (8) @(posedge CLK_SYS);
      bus_read(REG_STAT, rd);
      check("startup_done", 32'h1, {31'h0, rd[STAT_DONE]});
      check("hold_done", 32'h0, {31'h0, CPU_HOLD});
    end
    // Switch waits for a ready source, then completes.
    bus_write(REG_CTRL, 8'h31, 4'h1);
    repeat (40) @(posedge CLK_SYS);
    bus_read(REG_STAT, rd);
    check("src_kept", {30'h0, SRC_PRI}, {30'h0, rd[STAT_SRC_LSB +: 2]});
    check("busy_wait", 32'h1, {31'h0, rd[STAT_BUSY]});
    // The old primary clock keeps driving the output.
    check_clk(64, 8);
    SECONDARY_OSC_READY <= 1'b1;
    wait_src(SRC_SEC);
    check_clk(64, 4);
    bus_write(REG_CTRL, 8'h32, 4'h1);
    wait_src(SRC_INT);
    check_clk(256, 2);
    // The lowest option passes the slow oscillator untouched.
    bus_write(REG_CTRL, 8'h02, 4'h1);
    check_clk(256, 4);
    // The low-frequency select bit appears on its output pin.
    bus_write(REG_TRIM, 8'h80, 4'h1);
    check("low_freq_on", 32'h1, {31'h0, LOW_FREQ_SOURCE_SELECT});
    bus_write(REG_TRIM, 8'h00, 4'h1);
    // Multiplier feeds from the internal source only with select 00.
    PRIMARY_CLOCK_CONFIG <= PCFG_INT_A;
    repeat (6) @(posedge CLK_SYS);
    check("mult_in_1x", 32'h0, {31'h0, MULTIPLIER_INPUT_INTERNAL});
    bus_write(REG_CTRL, 8'h60, 4'h1);
    repeat (6) @(posedge CLK_SYS);
    check("mult_in_00", 32'h1, {31'h0, MULTIPLIER_INPUT_INTERNAL});
    print_verdict();
  end
endmodule : tb_osc_tune_switch_pll_control
